// >>> cgs_gain_regs.v
// register 5 gain subregister bank with sequential readback
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "cgs_defines.vh"

module cgs_gain_regs
#(
    // arbitrary value for the read-only version subregister
    parameter [5:0] CHIP_VERSION = 6'h01
)
(
    // clock and reset
    input  wire                    sys_clk,
    input  wire                    reset,
    // register port
    input  wire [`CGS_ADDR_W-1:0]  reg_addr,
    input  wire [7:0]              reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [7:0]              reg_rdata,
    // adc gain path
    output reg  [5:0]              adc_gain_code,
    output wire                    adc_gain_mute,
    output wire [6:0]              adc_gain_db,
    // dac gain path
    output reg  [5:0]              dac_gain_code,
    output wire                    dac_gain_mute,
    output wire [6:0]              dac_gain_db,
    // sidetone and input buffer
    output reg  [2:0]              sidetone_gain_code,
    output wire                    sidetone_mute,
    output wire [4:0]              sidetone_atten_db,
    output reg  [1:0]              input_buffer_gain_code,
    output wire [4:0]              input_buffer_gain_db,
    // next subregister a read will return
    output reg  [1:0]              read_seq_pos
);

    wire       reg5_hit;
    wire       reg5_wr;
    wire       reg5_rd;
    wire [1:0] wr_sel;
    reg  [7:0] seq_byte;
    reg  [7:0] rdata_next;
    reg  [1:0] seq_next;

    assign reg5_hit = (reg_addr == `CGS_ADDR_REG5);
    assign reg5_wr  = reg_wr & reg5_hit;
    assign reg5_rd  = reg_rd & reg5_hit;
    assign wr_sel   = reg_wdata[`CGS_SEL_HI:`CGS_SEL_LO];

    // gain subregisters
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            adc_gain_code          <= `CGS_GAIN_RESET;
            dac_gain_code          <= `CGS_GAIN_RESET;
            sidetone_gain_code     <= `CGS_STG_RESET;
            input_buffer_gain_code <= `CGS_IBG_RESET;
        end
        else if (reg5_wr)
        begin
            case (wr_sel)
                `CGS_SEL_ADC:
                    adc_gain_code <=
                        reg_wdata[`CGS_GAIN_HI:`CGS_GAIN_LO];
                `CGS_SEL_DAC:
                    dac_gain_code <=
                        reg_wdata[`CGS_GAIN_HI:`CGS_GAIN_LO];
                `CGS_SEL_STB:
                begin
                    // bit 2 is dropped here
                    sidetone_gain_code <=
                        reg_wdata[`CGS_STG_HI:`CGS_STG_LO];
                    input_buffer_gain_code <=
                        reg_wdata[`CGS_IBG_HI:`CGS_IBG_LO];
                end
                default:
                    // version subregister is read only
                    adc_gain_code <= adc_gain_code;
            endcase
        end
    end

    // byte for the current read sequence position
    always @*
    begin
        case (read_seq_pos)
            `CGS_RSEQ_ADC: seq_byte = {`CGS_SEL_ADC, adc_gain_code};
            `CGS_RSEQ_DAC: seq_byte = {`CGS_SEL_DAC, dac_gain_code};
            `CGS_RSEQ_STB: seq_byte = {`CGS_SEL_STB, sidetone_gain_code,
                                       1'b0, input_buffer_gain_code};
            `CGS_RSEQ_VER: seq_byte = {`CGS_SEL_VER, CHIP_VERSION};
            default:       seq_byte = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always @*
    begin
        rdata_next = 8'h00;
        if (reg5_rd)
            rdata_next = seq_byte;
    end

    // sequence steps on each register 5 read; a write restarts it
    always @*
    begin
        seq_next = read_seq_pos;
        if (reg5_wr)
            seq_next = `CGS_RSEQ_ADC;
        else if (reg5_rd)
            seq_next = read_seq_pos + 2'h1;
    end

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            reg_rdata    <= 8'h00;
            read_seq_pos <= `CGS_RSEQ_ADC;
        end
        else
        begin
            reg_rdata    <= rdata_next;
            read_seq_pos <= seq_next;
        end
    end

    // decoders
    cgs_pga_decode u_adc_dec
    (
        .gain_code (adc_gain_code),
        .gain_mute (adc_gain_mute),
        .gain_db   (adc_gain_db)
    );

    // below-zero codes follow the same linear decode
    cgs_pga_decode u_dac_dec
    (
        .gain_code (dac_gain_code),
        .gain_mute (dac_gain_mute),
        .gain_db   (dac_gain_db)
    );

    cgs_stb_decode u_stb_dec
    (
        .sidetone_gain_code     (sidetone_gain_code),
        .input_buffer_gain_code (input_buffer_gain_code),
        .sidetone_mute          (sidetone_mute),
        .sidetone_atten_db      (sidetone_atten_db),
        .input_buffer_gain_db   (input_buffer_gain_db)
    );

endmodule // cgs_gain_regs

`default_nettype wire

// >>> cgs_defines.vh
// constants for the codec gain subregister block
`ifndef CGS_DEFINES_VH
`define CGS_DEFINES_VH

// register map, register-select port is three bits wide
`define CGS_ADDR_W          3
`define CGS_ADDR_REG5       3'h5

// subregister select field, bits 7..6 of every register 5 byte
`define CGS_SEL_HI          7
`define CGS_SEL_LO          6
`define CGS_SEL_ADC         2'h0
`define CGS_SEL_DAC         2'h1
`define CGS_SEL_STB         2'h2
`define CGS_SEL_VER         2'h3

// gain code field, bits 5..0
`define CGS_GAIN_HI         5
`define CGS_GAIN_LO         0
`define CGS_GAIN_RESET      6'h2a
`define CGS_GAIN_MUTE       6'h3f
`define CGS_GAIN_ZERO_DB    7'h2a

// sidetone field bits 5..3, reserved bit 2, buffer gain bits 1..0
`define CGS_STG_HI          5
`define CGS_STG_LO          3
`define CGS_STG_RESET       3'h7
`define CGS_STG_MUTE        3'h7
`define CGS_STG_STEP_DB     5'h03
`define CGS_RSV_BIT         2
`define CGS_IBG_HI          1
`define CGS_IBG_LO          0
`define CGS_IBG_RESET       2'h0

// input buffer gain values in dB
`define CGS_IBG_DB_00       5'h00
`define CGS_IBG_DB_01       5'h06
`define CGS_IBG_DB_10       5'h0c
`define CGS_IBG_DB_11       5'h18

// read sequence positions
`define CGS_RSEQ_ADC        2'h0
`define CGS_RSEQ_DAC        2'h1
`define CGS_RSEQ_STB        2'h2
`define CGS_RSEQ_VER        2'h3

`endif

// >>> cgs_pga_decode.v
// gain code to mute flag and signed dB value
`timescale 1ns/1ns
`default_nettype none
`include "cgs_defines.vh"

module cgs_pga_decode
(
    // code in
    input  wire [5:0] gain_code,
    // decoded gain
    output wire       gain_mute,
    output wire [6:0] gain_db
);

    // all ones is mute; otherwise dB = code - 42, two's complement
    assign gain_mute = (gain_code == `CGS_GAIN_MUTE);
    assign gain_db   = gain_mute ? 7'h00
                     : ({1'b0, gain_code} - `CGS_GAIN_ZERO_DB);

endmodule // cgs_pga_decode

`default_nettype wire

// >>> cgs_stb_decode.v
// sidetone attenuation and input buffer gain decode
`timescale 1ns/1ns
`default_nettype none
`include "cgs_defines.vh"

module cgs_stb_decode
(
    // codes in
    input  wire [2:0] sidetone_gain_code,
    input  wire [1:0] input_buffer_gain_code,
    // decoded values
    output wire       sidetone_mute,
    output wire [4:0] sidetone_atten_db,
    output reg  [4:0] input_buffer_gain_db
);

    assign sidetone_mute = (sidetone_gain_code == `CGS_STG_MUTE);
    // attenuation = 3 dB * (code + 1); code 7 is mute and reads 0
    assign sidetone_atten_db = sidetone_mute ? 5'h00
        : (({2'h0, sidetone_gain_code} + 5'h01) * `CGS_STG_STEP_DB);

    always @*
    begin
        case (input_buffer_gain_code)
            2'h0:    input_buffer_gain_db = `CGS_IBG_DB_00;
            2'h1:    input_buffer_gain_db = `CGS_IBG_DB_01;
            2'h2:    input_buffer_gain_db = `CGS_IBG_DB_10;
            2'h3:    input_buffer_gain_db = `CGS_IBG_DB_11;
            default: input_buffer_gain_db = `CGS_IBG_DB_00;
        endcase
    end

endmodule // cgs_stb_decode

`default_nettype wire

// >>> cgs_props.sv
// assertions for the gain subregister bank
`timescale 1ns/1ns
`default_nettype none
module cgs_props
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       reset,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // subregister state
    input wire logic [5:0] adc_gain_code,
    input wire logic [5:0] dac_gain_code,
    input wire logic       dac_gain_mute,
    input wire logic [6:0] dac_gain_db,
    input wire logic [2:0] sidetone_gain_code,
    input wire logic       sidetone_mute,
    input wire logic [4:0] sidetone_atten_db,
    input wire logic [1:0] input_buffer_gain_code,
    input wire logic [4:0] input_buffer_gain_db,
    input wire logic [1:0] read_seq_pos
);
    wire hit = reg_addr == 3'h5;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_rd_sel: assert property (
        reg_rd && hit |=> reg_rdata[7:6] == $past(read_seq_pos)
    ) else $error("read order wrong");
    a_seq_step: assert property (
        reg_rd && hit |=> read_seq_pos == $past(read_seq_pos) + 2'h1
    ) else $error("read sequence stuck");
    a_dac_wr: assert property (
        reg_wr && hit && reg_wdata[7:6] == 2'h1
        |=> dac_gain_code == $past(reg_wdata[5:0])
    ) else $error("dac code not loaded");
    a_stb_wr: assert property (
        reg_wr && hit && reg_wdata[7:6] == 2'h2 |=> sidetone_gain_code
        == $past(reg_wdata[5:3])
        && input_buffer_gain_code == $past(reg_wdata[1:0])
    ) else $error("sidetone byte not loaded");
    a_dac_decode: assert property (
        dac_gain_mute == (dac_gain_code == 6'h3f) && dac_gain_db ==
        (dac_gain_mute ? 7'h00 : {1'b0, dac_gain_code} - 7'h2a)
    ) else $error("dac gain decode wrong");
    a_stb_decode: assert property (
        sidetone_atten_db == (sidetone_mute ? 5'h00 : 5'h03 *
        {2'b00, sidetone_gain_code} + 5'h03) && input_buffer_gain_db ==
        (&input_buffer_gain_code ? 5'h18 : 5'h06 * {3'h0, input_buffer_gain_code})
    ) else $error("sidetone or buffer decode wrong");
    a_reset_vals: assert property (
        $fell(reset) |-> {adc_gain_code, dac_gain_code, sidetone_gain_code,
        input_buffer_gain_code} == {6'h2a, 6'h2a, 3'h7, 2'h0}
    ) else $error("reset values wrong");
    a_rsv_zero: assert property (
        reg_rd && hit && read_seq_pos == 2'h2 |=> reg_rdata[2] == 1'b0
    ) else $error("reserved bit not zero");
    c_read: cover property (reg_rd && hit);
    c_stb: cover property (reg_wr && hit && reg_wdata[7:6] == 2'h2);
    c_mute: cover property (dac_gain_mute);
endmodule // cgs_props
bind cgs_gain_regs cgs_props i_props (.*);
`default_nettype wire

// >>> cgs_host.sv
// host processor model driving the register port
`timescale 1ns/1ns
`default_nettype none
module cgs_host
(
    // clock
    input  wire logic       sys_clk,
    // register port
    output var  logic [2:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task wr(input logic [2:0] a, input logic [7:0] d);
    begin
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    end
    endtask
    task rd(input logic [2:0] a, output logic [7:0] d);
    begin
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    end
    endtask
endmodule // cgs_host
`default_nettype wire

// >>> cgs_gain_regs_tb.sv
// testbench for the gain subregister bank
`timescale 1ns/1ns
`default_nettype none
module cgs_gain_regs_tb;
    localparam logic [5:0] VER = 6'h15; // arbitrary version value
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    wire [7:0] reg_wdata, reg_rdata;
    wire [6:0] adc_gain_db, dac_gain_db;
    wire [5:0] adc_gain_code, dac_gain_code;
    wire [4:0] sidetone_atten_db, input_buffer_gain_db;
    wire [2:0] reg_addr, sidetone_gain_code;
    wire [1:0] input_buffer_gain_code, read_seq_pos;
    wire reg_wr, reg_rd, adc_gain_mute, dac_gain_mute, sidetone_mute;
    int miscompares = 0;
    int n_checks = 0;
    logic [7:0] d;
    logic [7:0] seq [4] = '{8'h2a, 8'h6a, 8'hb8, {2'b11, VER}};
    logic [7:0] ibg_db [4] = '{8'h00, 8'h06, 8'h0c, 8'h18};
    logic [5:0] codes [5] = '{6'h3f, 6'h3e, 6'h2a, 6'h29, 6'h00};
    // expected dB per code above, two's complement, mute reads 0
    logic [6:0] db_exp [5] = '{7'h00, 7'h14, 7'h00, 7'h7f, 7'h56};
    always #20 sys_clk = ~sys_clk;
    cgs_gain_regs #(.CHIP_VERSION(VER)) i_dut (.*);
    cgs_host i_host (.*);
    task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    initial
    begin
        #100000;
        miscompares++;
        end_sim;
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk({input_buffer_gain_code, sidetone_gain_code}, 8'h07);
        foreach (seq[i])
        begin
            i_host.rd(3'h5, d);
            chk(d, seq[i]);
        end
        i_host.rd(3'h5, d);
        chk(d, seq[0]);
        $display("test reset done");
        foreach (codes[i])
        begin
            i_host.wr(3'h5, {2'b01, codes[i]});
            chk({dac_gain_mute, 1'b0, dac_gain_code}, {&codes[i], 1'b0, codes[i]});
            chk({1'b0, dac_gain_db}, {1'b0, db_exp[i]});
        end
        i_host.wr(3'h5, 8'h05);
        i_host.wr(3'h5, 8'hff);
        i_host.wr(3'h4, 8'h7e);
        chk({2'b00, adc_gain_code}, 8'h05);
        chk({adc_gain_mute, adc_gain_db}, 8'h5b);
        chk({2'b00, dac_gain_code}, 8'h00);
        i_host.rd(3'h4, d);
        chk(d, 8'h00);
        $display("test gain done");
        for (int s = 0; s < 8; s++)
        begin
            i_host.wr(3'h5, {2'b10, s[2:0], 1'b1, s[1:0]});
            repeat (3) i_host.rd(3'h5, d);
            chk(d, {2'b10, s[2:0], 1'b0, s[1:0]});
            chk({2'b00, sidetone_mute, sidetone_atten_db}, s == 7 ? 8'h20 : 8'(3 * s + 3));
            chk({3'b0, input_buffer_gain_db}, ibg_db[s % 4]);
        end
        $display("test sidetone done");
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk({adc_gain_code, 2'b00}, 8'ha8);
        chk({dac_gain_code, input_buffer_gain_code}, 8'ha8);
        chk({5'h00, sidetone_gain_code}, 8'h07);
        i_host.rd(3'h5, d);
        chk(d, seq[0]);
        $display("test mid-run reset done");
        end_sim;
    end
endmodule // cgs_gain_regs_tb
`default_nettype wire
